// ---- hw/tmz_timer0.sv ----
// Timer/counter with an 8-bit prescaler shared with the watchdog, behind a plain register port.
// Assumes one 200 MHz clock equals one oscillator period, and that ext_count_clock is synchronous.
`timescale 1ns/1ps
`include "tmz_defs.svh"

module tmz_timer0 #(
  parameter int PRESCALE_BITS = 8
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire tmz_pkg::tmz_req_t req,
  output logic [7:0]            rdata,
  input  wire logic             sleep,
  input  wire logic             ext_count_clock,
  input  wire logic             wdt_tick_in,
  output logic                  wdt_tick_out,
  output logic                  wdt_clear_out,
  output logic                  overflow_irq,
  output logic [7:0]            timer_count_out,
  output logic [4:0]            port_a_dir_out
);

  // ================================================================
  // Whole module state in one packed struct.
  typedef struct packed {
    logic [7:0]               count;
    logic [7:0]               config_r;
    logic                     flag;
    logic                     irq_en;
    logic [4:0]               ic_other;
    logic [4:0]               porta_dir;
    logic [PRESCALE_BITS-1:0] presc;
    logic [1:0]               inhibit;
    logic [1:0]               phase;
    logic                     ext_q;
    logic                     src_s1;
    logic                     src_s2;
    logic                     src_prev;
    logic [7:0]               rdata;
    logic                     irq;
    logic                     wdt_tick;
    logic                     wdt_clr;
  } tmz_state_t;

  tmz_state_t s_q;
  tmz_state_t s_d;

  // ================================================================
  // Helpers for the prescaler tap and the address decode.

  // Selected prescaler tap for a rate code; ratio 2^(n+1) or 2^n.
  function automatic logic presc_tap(input logic [PRESCALE_BITS-1:0] p, input logic [2:0] n,
                                     input logic timer_side);
    logic [3:0] idx;
    idx = timer_side ? {1'b0, n} : ({1'b0, n} - 4'd1);
    presc_tap = p[idx[2:0]];
  endfunction

  function automatic logic is_addr(input tmz_pkg::tmz_req_t r, input logic [7:0] a);
    is_addr = (r.addr == a);
  endfunction

  // Field decode of the config register.
  tmz_pkg::tmz_mode_t mode;
  logic               edge_fall;
  logic               to_watchdog;
  logic [2:0]         rate;
  assign mode        = tmz_pkg::tmz_mode_t'(s_q.config_r[`TMZ_CFG_SOURCE]);
  assign edge_fall   = s_q.config_r[`TMZ_CFG_EDGE];
  assign to_watchdog = s_q.config_r[`TMZ_CFG_ASSIGN];
  assign rate        = s_q.config_r[`TMZ_CFG_RATE_HI:`TMZ_CFG_RATE_LO];

  // ================================================================
  // Next-state logic.
  logic wr_count;
  logic wr_cmd_clear;
  logic ext_edge;
  logic cycle_tick;
  logic presc_clk;
  logic presc_out;
  logic src_rise;
  logic inc;
  logic [8:0] count_sum;
  logic [PRESCALE_BITS-1:0] wmask;

  always_comb begin
    s_d = s_q;
    wr_count     = req.wr && is_addr(req, `TMZ_ADDR_COUNT);
    wr_cmd_clear = req.wr && is_addr(req, `TMZ_ADDR_CMD) && req.wdata[`TMZ_CMD_WDT_CLEAR];

    // Phase counter, gives Q1..Q4 over four oscillator periods.
    s_d.phase  = sleep ? s_q.phase : s_q.phase + 2'd1;
    cycle_tick = !sleep && (s_q.phase == `TMZ_PHASES);

    // Counting edge, inverted for the falling option.
    s_d.ext_q = ext_count_clock ^ edge_fall;
    ext_edge  = (ext_count_clock ^ edge_fall) && !s_q.ext_q;

    // Prescaler input comes from its single owner.
    if (to_watchdog) begin
      presc_clk = wdt_tick_in;
    end else if (mode == tmz_pkg::TMZ_MODE_COUNTER) begin
      presc_clk = ext_edge; // Driven by external edges ahead of sync.
    end else begin
      presc_clk = cycle_tick;
    end

    // Count writes reset the prescaler when the timer owns it, watchdog clears when the watchdog does.
    if ((wr_count && !to_watchdog) || (wr_cmd_clear && to_watchdog)) begin
      s_d.presc = '0;
    end else if (presc_clk) begin
      s_d.presc = s_q.presc + 1'b1;
    end

    // Tap is a toggling bit, so the divided output is symmetrical.
    presc_out = presc_tap(s_q.presc, rate, !to_watchdog);

    // Counter-mode source: prescaler bit or raw edge-adjusted input.
    if (!to_watchdog) begin
      s_d.src_s1 = presc_out;
    end else begin
      s_d.src_s1 = s_q.ext_q;
    end
    // Sampling only on Q2 and Q4 phases.
    if (s_q.phase == tmz_pkg::TMZ_Q2 || s_q.phase == tmz_pkg::TMZ_Q4) begin
      s_d.src_s2 = s_q.src_s1;
    end
    s_d.src_prev = s_q.src_s2;
    // Edge reaches the count three to five periods after the pin.
    src_rise = s_q.src_s2 && !s_q.src_prev;

    // Timer mode: instruction cycles, or prescaler edges when assigned.
    if (mode == tmz_pkg::TMZ_MODE_TIMER) begin
      if (to_watchdog) begin
        inc = cycle_tick;
      end else begin
        inc = src_rise;
      end
    end else begin
      inc = src_rise;
    end
    if (sleep) begin
      inc = 1'b0;
    end

    // Two-cycle inhibit after a count write.
    if (cycle_tick && s_q.inhibit != 2'd0) begin
      s_d.inhibit = s_q.inhibit - 2'd1;
    end
    count_sum = {1'b0, s_q.count} + 9'd1;
    if (wr_count) begin
      s_d.count   = req.wdata;
      s_d.inhibit = `TMZ_INHIBIT_CYC;
    end else if (inc && s_q.inhibit == 2'd0) begin
      s_d.count = count_sum[7:0];
    end

    // Interrupt control register write; software clears the flag.
    if (req.wr && is_addr(req, `TMZ_ADDR_INTCTL)) begin
      s_d.flag     = req.wdata[`TMZ_IC_FLAG];
      s_d.irq_en   = req.wdata[`TMZ_IC_ENABLE];
      s_d.ic_other = {req.wdata[7:6], req.wdata[4:3], req.wdata[1]};
    end
    // Wrap sets the flag, winning over a same-cycle clear.
    if (!wr_count && inc && s_q.inhibit == 2'd0 && count_sum[8]) begin
      s_d.flag = 1'b1;
    end

    if (req.wr && is_addr(req, `TMZ_ADDR_CONFIG)) begin
      s_d.config_r = req.wdata;
    end
    if (req.wr && is_addr(req, `TMZ_ADDR_PORTA_DIR)) begin
      s_d.porta_dir = req.wdata[4:0];
    end

    s_d.irq = s_d.flag && s_d.irq_en;

    // Watchdog tick: divided when owner, raw otherwise.
    // The tick is the carry out of the low rate bits, so a clear never fakes a tick
    // and the first tick after a clear comes after a full ratio of input ticks.
    wmask        = (PRESCALE_BITS'(1) << rate) - PRESCALE_BITS'(1);
    s_d.wdt_tick = to_watchdog ? (wdt_tick_in && !wr_cmd_clear && ((s_q.presc & wmask) == wmask))
                               : wdt_tick_in;
    s_d.wdt_clr  = wr_cmd_clear;

    // Read mux; prescaler is never visible, unmapped reads zero.
    s_d.rdata = 8'h00;
    if (req.rd) begin
      case (req.addr)
        `TMZ_ADDR_COUNT:     s_d.rdata = s_q.count;
        `TMZ_ADDR_INTCTL:    s_d.rdata = {s_q.ic_other[4:3], s_q.irq_en, s_q.ic_other[2:1], s_q.flag, s_q.ic_other[0],
                                          1'b0};
        `TMZ_ADDR_CONFIG:    s_d.rdata = s_q.config_r;
        `TMZ_ADDR_PORTA_DIR: s_d.rdata = {3'b000, s_q.porta_dir};
        default:             s_d.rdata = 8'h00;
      endcase
    end
  end

  // ================================================================
  // State register with synchronous reset.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_q           <= '0;
      s_q.config_r  <= `TMZ_RST_CONFIG;
      s_q.porta_dir <= `TMZ_RST_PORTA_DIR;
      s_q.count     <= `TMZ_RST_COUNT;
      // Reset config counts falling edges, so an idle low pin reads high here.
      // Starting the sync chain high avoids a false count right after reset.
      s_q.ext_q     <= 1'b1;
      s_q.src_s1    <= 1'b1;
      s_q.src_s2    <= 1'b1;
      s_q.src_prev  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state flip-flops.
  assign rdata           = s_q.rdata;
  assign overflow_irq    = s_q.irq;
  assign timer_count_out = s_q.count;
  assign port_a_dir_out  = s_q.porta_dir;
  assign wdt_tick_out    = s_q.wdt_tick;
  assign wdt_clear_out   = s_q.wdt_clr;

  // ================================================================
  // Assertions.
  // Properties using |=> look one edge after their cause; a_irq_masked, a_irq_follows and the edge and sync checks use |-> instead.

  a_flag_on_wrap: assert property (@(posedge clk) disable iff (!rstn)
    (inc && s_q.inhibit == 2'd0 && s_q.count == 8'hff && !wr_count) |=> s_q.flag)
    else $error("overflow did not set the flag");

  a_irq_masked: assert property (@(posedge clk) disable iff (!rstn)
    !s_q.irq_en |-> !overflow_irq)
    else $error("interrupt raised while masked");

  a_irq_follows: assert property (@(posedge clk) disable iff (!rstn)
    overflow_irq |-> (s_q.flag && s_q.irq_en))
    else $error("interrupt raised without flag and enable");

  a_flag_sticky: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.flag && !(req.wr && is_addr(req, `TMZ_ADDR_INTCTL))) |=> s_q.flag)
    else $error("hardware cleared the overflow flag");

  a_write_inhibit: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.inhibit != 2'd0 && !wr_count) |=> $stable(s_q.count))
    else $error("count moved during write inhibit");

  a_write_lands: assert property (@(posedge clk) disable iff (!rstn)
    wr_count |=> (s_q.count == $past(req.wdata) && s_q.inhibit == `TMZ_INHIBIT_CYC))
    else $error("count write did not land or arm the inhibit");

  a_sleep_frozen: assert property (@(posedge clk) disable iff (!rstn)
    (sleep && !wr_count) |=> $stable(s_q.count))
    else $error("count moved in sleep");

  a_sleep_phase: assert property (@(posedge clk) disable iff (!rstn)
    sleep |=> $stable(s_q.phase))
    else $error("phase moved in sleep");

  a_presc_clear_wr: assert property (@(posedge clk) disable iff (!rstn)
    (wr_count && !to_watchdog) |=> s_q.presc == '0)
    else $error("prescaler not cleared by count write");

  a_presc_clear_wdt: assert property (@(posedge clk) disable iff (!rstn)
    (wr_cmd_clear && to_watchdog) |=> s_q.presc == '0)
    else $error("prescaler not cleared by watchdog clear");

  a_presc_owner: assert property (@(posedge clk) disable iff (!rstn)
    (to_watchdog && !wr_cmd_clear) |=> s_q.presc == $past(s_q.presc) + PRESCALE_BITS'($past(wdt_tick_in)))
    else $error("prescaler not driven by the watchdog ticks");

  a_presc_ext: assert property (@(posedge clk) disable iff (!rstn)
    (mode == tmz_pkg::TMZ_MODE_COUNTER && !to_watchdog && ext_edge && !wr_count) |=>
     s_q.presc == $past(s_q.presc) + PRESCALE_BITS'(1))
    else $error("prescaler missed an external edge");

  a_wdt_undivided: assert property (@(posedge clk) disable iff (!rstn)
    !to_watchdog |=> wdt_tick_out == $past(wdt_tick_in))
    else $error("watchdog tick divided without the prescaler");

  a_wdt_rate_one: assert property (@(posedge clk) disable iff (!rstn)
    (to_watchdog && rate == 3'd0) |=> wdt_tick_out == $past(wdt_tick_in && !wr_cmd_clear))
    else $error("watchdog ratio one not passed through");

  a_timer_rate: assert property (@(posedge clk) disable iff (!rstn)
    (mode == tmz_pkg::TMZ_MODE_TIMER && to_watchdog && !sleep && !wr_count && s_q.inhibit == 2'd0 &&
     s_q.phase == 2'd3) |=> s_q.count == $past(s_q.count) + 8'd1)
    else $error("timer mode did not advance once per cycle");

  a_counter_src: assert property (@(posedge clk) disable iff (!rstn)
    (mode == tmz_pkg::TMZ_MODE_COUNTER && !src_rise && !wr_count) |=> $stable(s_q.count))
    else $error("counter mode moved without a synchronised edge");

  a_edge_rise: assert property (@(posedge clk) disable iff (!rstn)
    ($rose(ext_count_clock) && !edge_fall && $stable(edge_fall)) |-> ext_edge)
    else $error("rising edge not detected");

  a_edge_fall: assert property (@(posedge clk) disable iff (!rstn)
    ($fell(ext_count_clock) && edge_fall && $stable(edge_fall)) |-> ext_edge)
    else $error("falling edge not detected");

  a_sample_phase: assert property (@(posedge clk) disable iff (!rstn)
    (s_q.phase == 2'd0 || s_q.phase == 2'd2) |=> $stable(s_q.src_s2))
    else $error("sync sample taken off the sampling phases");

  a_sync_delay: assert property (@(posedge clk) disable iff (!rstn)
    (mode == tmz_pkg::TMZ_MODE_COUNTER && to_watchdog && ext_edge && !sleep) |-> ##[2:5] src_rise)
    else $error("external edge not synchronised in time");

  a_rd_zero: assert property (@(posedge clk) disable iff (!rstn)
    !req.rd |=> rdata == 8'h00)
    else $error("read data outside the read slot");

  a_rd_count: assert property (@(posedge clk) disable iff (!rstn)
    (req.rd && req.addr == `TMZ_ADDR_COUNT) |=> rdata == $past(s_q.count))
    else $error("count read returned the wrong value");

endmodule // tmz_timer0

// ---- hw/tmz_defs.svh ----
// Register offsets, field positions, reset values and timing counts of the timer block.
// Assumes inclusion by bare name from the design file and the testbench.
`ifndef TMZ_DEFS_SVH
`define TMZ_DEFS_SVH

// ==================================================================
// Register offsets (byte addresses on the plain register port).
`define TMZ_ADDR_COUNT     8'h01
`define TMZ_ADDR_INTCTL    8'h0b
`define TMZ_ADDR_CONFIG    8'h81
`define TMZ_ADDR_PORTA_DIR 8'h85
`define TMZ_ADDR_CMD       8'hf0

// ==================================================================
// Field positions in the timer config register.
`define TMZ_CFG_RATE_LO    0
`define TMZ_CFG_RATE_HI    2
`define TMZ_CFG_ASSIGN     3
`define TMZ_CFG_EDGE       4
`define TMZ_CFG_SOURCE     5

// Field positions in the interrupt control register.
`define TMZ_IC_FLAG        2
`define TMZ_IC_ENABLE      5

// Command register: bit 0 clears the watchdog, and the shared prescaler when it is assigned to the watchdog.
`define TMZ_CMD_WDT_CLEAR  0

// ==================================================================
// Reset values.
`define TMZ_RST_CONFIG     8'hff
`define TMZ_RST_INTCTL     8'h00
`define TMZ_RST_PORTA_DIR  5'h1f
`define TMZ_RST_COUNT      8'h00

// ==================================================================
// Timing: last oscillator phase of an instruction cycle, write inhibit length.
`define TMZ_PHASES         2'd3
`define TMZ_INHIBIT_CYC    2'd2

`endif

// ---- hw/tmz_pkg.sv ----
// Types shared by the timer block: register bus request, clock source mode and instruction phase.
// Assumes tmz_defs.svh lies on the include path.
package tmz_pkg;

  // ================================================================
  // Register port request, driven by the CPU side.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tmz_req_t;

  // Decoded clock source, kept as a named mode.
  typedef enum logic [0:0] {
    TMZ_MODE_TIMER   = 1'b0,
    TMZ_MODE_COUNTER = 1'b1
  } tmz_mode_t;

  // Instruction phase within one cycle of four oscillator periods.
  typedef enum logic [1:0] {
    TMZ_Q1 = 2'b00,
    TMZ_Q2 = 2'b01,
    TMZ_Q3 = 2'b10,
    TMZ_Q4 = 2'b11
  } tmz_phase_t;

endpackage

// ---- testbench/tmz_far_src.sv ----
// Far-side model: the external count clock source and the watchdog oscillator ticks.
// Assumes the testbench calls its tasks and that clk is the block clock.
`timescale 1ns/1ps

module tmz_far_src (
  input  wire logic clk,
  output logic      ext_count_clock,
  output logic      wdt_tick_in
);
  // ==================================================================
  // Idle levels from time zero, so the block never sees an unknown input.
  initial begin
    ext_count_clock = 1'b0;
    wdt_tick_in     = 1'b0;
  end

  // Each level stands eight clocks, 40 ns, which leaves margin over the sampler.
  // minimum pulse widths
  // A 16-clock period also meets the prescaled minimum.
  task automatic toggle(input int n);
    repeat (n) begin
      @(posedge clk);
      ext_count_clock <= ~ext_count_clock;
      repeat (7) @(posedge clk);
    end
  endtask

  // One-cycle watchdog ticks, four clocks apart.
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      wdt_tick_in <= 1'b1;
      @(posedge clk);
      wdt_tick_in <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask
endmodule // tmz_far_src

// ---- testbench/testbench.sv ----
// Self-checking bench of the timer block: register port, timer, counter, overflow, sleep, watchdog path.
// Assumes tmz_defs.svh on the include path and the far-side model beside it.
`timescale 1ns/1ps
`include "tmz_defs.svh"

module testbench;
  logic              clk;
  logic              rstn;
  tmz_pkg::tmz_req_t req;
  logic [7:0]        rdata;
  logic              sleep;
  logic              ext_count_clock;
  logic              wdt_tick_in;
  logic              wdt_tick_out;
  logic              wdt_clear_out;
  logic              overflow_irq;
  logic [7:0]        timer_count_out;
  logic [4:0]        port_a_dir_out;
  int                failures;
  int                checks_done;
  int                cycles;
  int                n_tick;
  int                n_clr;
  logic [7:0]        v;

  tmz_timer0 tmz_timer0_i (.clk(clk), .rstn(rstn), .req(req), .rdata(rdata), .sleep(sleep),
    .ext_count_clock(ext_count_clock), .wdt_tick_in(wdt_tick_in), .wdt_tick_out(wdt_tick_out),
    .wdt_clear_out(wdt_clear_out), .overflow_irq(overflow_irq), .timer_count_out(timer_count_out),
    .port_a_dir_out(port_a_dir_out));
  tmz_far_src tmz_far_src_i (.clk(clk), .ext_count_clock(ext_count_clock), .wdt_tick_in(wdt_tick_in));

  // ==================================================================
  // Clock, watchdog pulse monitor and hang guard.
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    n_tick <= n_tick + (wdt_tick_out === 1'b1);
    n_clr  <= n_clr + (wdt_clear_out === 1'b1);
    if (cycles == 30000) begin
      failures = failures + 1;
      results();
    end
  end

  // ==================================================================
  // Shared tasks for the register port and comparisons.
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Count advance over a window; a whole number of periods makes it exact.
  task automatic delta(input int win, output logic [7:0] d);
    logic [7:0] a;
    @(posedge clk);
    #1 a = timer_count_out;
    repeat (win) @(posedge clk);
    #1 d = timer_count_out - a;
  endtask

  // ==================================================================
  // Scenarios.
  task automatic t_reset();
    rd(`TMZ_ADDR_CONFIG, v);    chk("config", `TMZ_RST_CONFIG, v);
    rd(`TMZ_ADDR_INTCTL, v);    chk("intctl", `TMZ_RST_INTCTL, v);
    rd(`TMZ_ADDR_PORTA_DIR, v); chk("portdir", 8'h1f, v);
    chk("portdir pin", 8'h1f, {3'h0, port_a_dir_out});
    wr(`TMZ_ADDR_PORTA_DIR, 8'h0a);
    rd(`TMZ_ADDR_PORTA_DIR, v); chk("portdir wr", 8'h0a, v);
    chk("portdir pin wr", 8'h0a, {3'h0, port_a_dir_out});
    rd(`TMZ_ADDR_COUNT, v);     chk("count", 8'h00, v);
    rd(8'h02, v);               chk("unmapped", 8'h00, v);
  endtask
  task automatic t_timer();
    wr(`TMZ_ADDR_CONFIG, 8'h08);
    wr(`TMZ_ADDR_COUNT, 8'h00);
    repeat (11) @(posedge clk);
    chk("inhibit", 8'h01, {7'h00, timer_count_out <= 8'h01});
    delta(40, v); chk("timer rate", 8'h0a, v);
    sleep <= 1'b1;
    delta(64, v); chk("sleep", 8'h00, v);
    sleep <= 1'b0;
  endtask
  task automatic t_overflow();
    wr(`TMZ_ADDR_INTCTL, 8'h00);
    wr(`TMZ_ADDR_COUNT, 8'hfe);
    repeat (40) @(posedge clk);
    rd(`TMZ_ADDR_INTCTL, v); chk("flag", 8'h04, v & 8'h04);
    chk("irq masked", 8'h00, {7'h00, overflow_irq});
    wr(`TMZ_ADDR_INTCTL, 8'h24);
    repeat (2) @(posedge clk);
    chk("irq on", 8'h01, {7'h00, overflow_irq});
    wr(`TMZ_ADDR_INTCTL, 8'h20);
    repeat (2) @(posedge clk);
    chk("irq cleared", 8'h00, {7'h00, overflow_irq});
  endtask
  // Rate codes 0 to 3 give periods of 8, 16, 32 and 64 clocks.
  task automatic t_prescale();
    for (int n = 0; n < 4; n++) begin
      wr(`TMZ_ADDR_CMD, 8'h01);
      wr(`TMZ_ADDR_CONFIG, 8'(n));
      wr(`TMZ_ADDR_COUNT, 8'h00);
      repeat (80) @(posedge clk);
      delta(256, v); chk("prescaled", 8'(32 >> n), v);
    end
  endtask
  task automatic t_counter();
    wr(`TMZ_ADDR_CONFIG, 8'h28);
    wr(`TMZ_ADDR_COUNT, 8'h00);
    repeat (10) @(posedge clk);
    tmz_far_src_i.toggle(3);
    chk("rise two", 8'h02, timer_count_out);
    wr(`TMZ_ADDR_CONFIG, 8'h38);
    wr(`TMZ_ADDR_COUNT, 8'h00);
    repeat (10) @(posedge clk);
    tmz_far_src_i.toggle(3);
    chk("fall two", 8'h02, timer_count_out);
  endtask
  task automatic t_watchdog();
    int t0;
    int c0;
    wr(`TMZ_ADDR_CMD, 8'h01);
    wr(`TMZ_ADDR_COUNT, 8'h00);
    wr(`TMZ_ADDR_CONFIG, 8'h2f);
    c0 = n_clr;
    wr(`TMZ_ADDR_CMD, 8'h01);
    wr(`TMZ_ADDR_CONFIG, 8'h09);
    chk("clear echo", 8'h01, 8'(n_clr - c0));
    tmz_far_src_i.ticks(1);
    wr(`TMZ_ADDR_CMD, 8'h01);
    t0 = n_tick;
    tmz_far_src_i.ticks(3);
    chk("postscale", 8'h01, 8'(n_tick - t0));
    wr(`TMZ_ADDR_CONFIG, 8'h01);
    t0 = n_tick;
    tmz_far_src_i.ticks(8);
    chk("wdt undivided", 8'h08, 8'(n_tick - t0));
  endtask
  // Counter mode through the prescaler at 1:2: four rising edges give two counts.
  task automatic t_ext_presc();
    wr(`TMZ_ADDR_CONFIG, 8'h20);
    wr(`TMZ_ADDR_COUNT, 8'h00);
    repeat (10) @(posedge clk);
    tmz_far_src_i.toggle(8);
    chk("ext prescaled", 8'h02, timer_count_out);
  endtask

  // ==================================================================
  // Verdict, the one place where the run ends.
  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    failures = 0;
    checks_done = 0;
    cycles = 0;
    n_tick = 0;
    n_clr = 0;
    rstn = 1'b0;
    sleep = 1'b0;
    req = '{addr: 8'h00, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_timer();
    t_overflow();
    t_prescale();
    t_counter();
    t_watchdog();
    t_ext_presc();
    results();
  end
endmodule // testbench
